// ==== rtl/scs_pkg.sv ====
/*
 * Constants, field layouts and carrier types shared by the serial command and
 * status interface of the LED driver.
 * Assumes a 125 MHz system clock and a 24-bit serial frame from an external master.
 */
package scs_pkg;

	// ----------------------------------------------------------------
	// Frame layout.
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 24;
	localparam int CMD_BITS = 8;
	localparam logic [4:0] CNT_FRAME = 5'h18;
	localparam logic [4:0] CNT_CMD = 5'h08;
	localparam logic [4:0] CNT_MAX = 5'h1f;

	// ----------------------------------------------------------------
	// Operation codes.
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_READ_CLEAR = 2'h2;
	localparam logic [1:0] OP_DEVICE_INFO = 2'h3;

	// ----------------------------------------------------------------
	// RAM map.
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_RAM_RESERVED = 6'h00;
	localparam logic [5:0] ADDR_CTRL_MUX_WATCHDOG = 6'h01;
	localparam logic [5:0] ADDR_CTRL_DITHER_CURRENT = 6'h02;
	localparam logic [5:0] ADDR_CTRL_LIMP_DELAY = 6'h03;
	localparam logic [5:0] ADDR_STATUS_DETAIL = 6'h04;
	localparam logic [5:0] ADDR_STATUS_WD_OPMODE = 6'h05;
	localparam logic [5:0] ADDR_TRIM_TEST_SELECT = 6'h3e;
	localparam logic [5:0] ADDR_CONFIG = 6'h3f;

	// ----------------------------------------------------------------
	// ROM map.
	// ----------------------------------------------------------------
	localparam logic [5:0] ROM_MAKER_HEADER = 6'h00;
	localparam logic [5:0] ROM_SILICON_REVISION = 6'h01;
	localparam logic [5:0] ROM_PART_CODE_A = 6'h02;
	localparam logic [5:0] ROM_PART_CODE_B = 6'h03;
	localparam logic [5:0] ROM_FRAME_FORMAT_ID = 6'h3e;
	localparam logic [15:0] FRAME_FORMAT_WORD = 16'h4200;

	// ----------------------------------------------------------------
	// Reset values of the writable registers.
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_MUX_WATCHDOG_RESET = 16'h000e;
	localparam logic [15:0] CTRL_DITHER_CURRENT_RESET = 16'h0000;
	localparam logic [15:0] CTRL_LIMP_DELAY_RESET = 16'h0000;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Bit positions inside the frame fault summary byte.
	// ----------------------------------------------------------------
	localparam int GS_ANY_FAULT = 7;
	localparam int GS_COMM_ERR = 6;
	localparam int GS_CHIP_OK = 5;
	localparam int GS_LED_OVERLOAD = 4;
	localparam int GS_TEMP_WARN = 3;
	localparam int GS_OVERVOLTAGE = 2;
	localparam int GS_MICRO_SUPPLY = 1;
	localparam int GS_FAIL_SAFE = 0;

	// ----------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 125;
	localparam int UV_HOLD_US = 2000;
	localparam int UV_HOLD_CYCLES = UV_HOLD_US * SYS_CLK_MHZ;

	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FRAME = 2'b10
	} scs_state_e;

	typedef struct packed {
		logic led_overload;
		logic temp_warning;
		logic chain_overvoltage_flag;
		logic supply_overvoltage_flag;
		logic supply_undervoltage_flag;
		logic light_mode_error;
		logic [3:0] regulated_micro_supply_errors;
		logic regulated_micro_supply_undervoltage;
		logic active_mode;
		logic limp_data_stuck;
		logic limp_watchdog_timeout;
		logic limp_software;
	} scs_faults_s;

	typedef struct packed {
		logic [15:0] detail;
		logic [15:0] wd_opmode;
	} scs_status_s;

endpackage

// ==== rtl/scs_top.sv ====
/*
 * Command and status layer of the 24-bit serial interface: frame capture on
 * the master's serial clock, command decode, RAM and ROM maps, fault summary.
 * Assumes fault and status event inputs come from logic on sys_clk, and that
 * the master holds chip select low at least three sys_clk periods before the
 * first serial clock edge and keeps the serial clock low while chip select moves.
 */

module scs_top #(
	parameter int UV_HOLD_CYCLES = scs_pkg::UV_HOLD_CYCLES,
	parameter logic [15:0] MAKER_HEADER = 16'h1234, // Arbitrary value.
	parameter logic [15:0] SILICON_REVISION = 16'h0001, // Arbitrary value.
	parameter logic [15:0] PART_CODE_A = 16'h00aa, // Arbitrary value.
	parameter logic [15:0] PART_CODE_B = 16'h00bb // Arbitrary value.
) (
	// System clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Serial link from the master.
	input wire logic spi_clk,
	input wire logic chip_select_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_en,
	// Fault conditions and status events from the device core.
	input wire scs_pkg::scs_faults_s faults,
	input wire scs_pkg::scs_status_s status_events,
	input wire logic [15:0] trim_test_select,
	// Register contents for the device core.
	output logic [15:0] ctrl_mux_watchdog,
	output logic [15:0] ctrl_dither_current,
	output logic [15:0] ctrl_limp_delay,
	output logic [15:0] config_watchdog_retrigger,
	output scs_pkg::scs_status_s status_regs
);

	// ----------------------------------------------------------------
	// Link domain.
	// ----------------------------------------------------------------
	logic [scs_pkg::FRAME_BITS-1:0] rx_shift;
	logic rx_toggle;
	logic tx_toggle;

	// Input bits are shifted in on the rising serial clock; the toggle marks each edge.
	always_ff @(posedge spi_clk or posedge chip_select_n) begin
		if (chip_select_n) begin
			rx_shift <= '0;
			rx_toggle <= 1'b0;
		end else begin
			rx_shift <= {rx_shift[scs_pkg::FRAME_BITS-2:0], serial_data_in};
			rx_toggle <= ~rx_toggle;
		end
	end

	// Each falling serial clock edge is passed over as a toggle to advance the output.
	always_ff @(negedge spi_clk or posedge chip_select_n) begin
		if (chip_select_n) begin
			tx_toggle <= 1'b0;
		end else begin
			tx_toggle <= ~tx_toggle;
		end
	end

	// ----------------------------------------------------------------
	// Crossing into the system domain.
	// ----------------------------------------------------------------
	logic cs_meta, cs_sync;
	logic rx_meta, rx_sync, rx_prev;
	logic tx_meta, tx_sync, tx_prev;
	logic rx_evt, tx_evt;

	// Two flip-flops for chip select and each toggle; edges come from the second stage.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			rx_meta <= 1'b0;
			rx_sync <= 1'b0;
			rx_prev <= 1'b0;
			tx_meta <= 1'b0;
			tx_sync <= 1'b0;
			tx_prev <= 1'b0;
		end else begin
			cs_meta <= chip_select_n;
			cs_sync <= cs_meta;
			rx_meta <= rx_toggle;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
			tx_meta <= tx_toggle;
			tx_sync <= tx_meta;
			tx_prev <= tx_sync;
		end
	end

	// The shift register is only read after its toggle arrives, so it is stable then.
	assign rx_evt = rx_sync ^ rx_prev;
	assign tx_evt = tx_sync ^ tx_prev;

	// ----------------------------------------------------------------
	// Frame sequencing.
	// ----------------------------------------------------------------
	scs_pkg::scs_state_e state;
	logic frame_start, frame_end, frame_ok;
	logic [4:0] rx_cnt;
	logic [4:0] tx_cnt;
	logic [1:0] cmd_op;
	logic [5:0] cmd_addr;

	assign frame_start = (state == scs_pkg::ST_IDLE) && !cs_sync;
	assign frame_end = (state == scs_pkg::ST_FRAME) && cs_sync;
	assign frame_ok = frame_end && (rx_cnt == scs_pkg::CNT_FRAME);

	// A frame runs from the synchronised chip select fall to its rise.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= scs_pkg::ST_IDLE;
		end else begin
			unique case (state)
				scs_pkg::ST_IDLE: begin
					if (!cs_sync) begin
						state <= scs_pkg::ST_FRAME;
					end
				end
				scs_pkg::ST_FRAME: begin
					if (cs_sync) begin
						state <= scs_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Edge counters saturate so an over-long frame can never wrap back to 24.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || frame_start) begin
			rx_cnt <= '0;
			tx_cnt <= '0;
		end else begin
			if (rx_evt && rx_cnt != scs_pkg::CNT_MAX) begin
				rx_cnt <= rx_cnt + 5'h01;
			end
			if (tx_evt && tx_cnt != scs_pkg::CNT_MAX) begin
				tx_cnt <= tx_cnt + 5'h01;
			end
		end
	end

	// The command byte is captured once its eighth bit has arrived.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmd_op <= scs_pkg::OP_WRITE;
			cmd_addr <= '0;
		end else if (rx_evt && rx_cnt == scs_pkg::CNT_CMD - 5'h01) begin
			cmd_op <= rx_shift[scs_pkg::CMD_BITS-1:scs_pkg::CMD_BITS-2];
			cmd_addr <= rx_shift[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Fault summary.
	// ----------------------------------------------------------------
	localparam int UVW = $clog2(UV_HOLD_CYCLES + 1);
	logic [UVW-1:0] uv_cnt;
	logic comm_err, chip_seen;
	logic [7:0] live_summary, summary;

	// Undervoltage in active mode must last the full hold time before it counts.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !(faults.regulated_micro_supply_undervoltage && faults.active_mode)) begin
			uv_cnt <= '0;
		end else if (uv_cnt != UVW'(UV_HOLD_CYCLES)) begin
			uv_cnt <= uv_cnt + UVW'(1);
		end
	end

	// Live summary; the any-fault bit folds in two flags not shown elsewhere.
	always_comb begin
		live_summary = '0;
		live_summary[scs_pkg::GS_COMM_ERR] = comm_err;
		live_summary[scs_pkg::GS_CHIP_OK] = chip_seen && !comm_err;
		live_summary[scs_pkg::GS_LED_OVERLOAD] = faults.led_overload;
		live_summary[scs_pkg::GS_TEMP_WARN] = faults.temp_warning;
		live_summary[scs_pkg::GS_OVERVOLTAGE] = faults.chain_overvoltage_flag
			|| faults.supply_overvoltage_flag;
		live_summary[scs_pkg::GS_MICRO_SUPPLY] = |faults.regulated_micro_supply_errors;
		live_summary[scs_pkg::GS_FAIL_SAFE] = faults.limp_data_stuck
			|| faults.limp_watchdog_timeout || faults.limp_software
			|| (uv_cnt == UVW'(UV_HOLD_CYCLES));
		live_summary[scs_pkg::GS_ANY_FAULT] = (|live_summary[6:0])
			|| faults.supply_undervoltage_flag || faults.light_mode_error;
	end

	// Communication state changes only at frame end; an empty frame is a fault peek.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			comm_err <= 1'b0;
			chip_seen <= 1'b0;
		end else if (frame_ok) begin
			comm_err <= 1'b0;
			chip_seen <= 1'b1;
		end else if (frame_end && rx_cnt != 5'h00) begin
			comm_err <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	logic do_write, do_clear;
	logic [15:0] wr_data;
	scs_pkg::scs_status_s pending;

	// The data field is copied once the last bit is in: a rising chip select clears the
	// shift register asynchronously, long before the frame end is seen on sys_clk.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_data <= '0;
		end else if (rx_evt && rx_cnt == scs_pkg::CNT_FRAME - 5'h01) begin
			wr_data <= rx_shift[15:0];
		end
	end

	assign do_write = frame_ok && cmd_op == scs_pkg::OP_WRITE;
	assign do_clear = frame_ok && cmd_op == scs_pkg::OP_READ_CLEAR;

	// Writable RAM words; reserved, status and trim slots ignore writes.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_mux_watchdog <= scs_pkg::CTRL_MUX_WATCHDOG_RESET;
			ctrl_dither_current <= scs_pkg::CTRL_DITHER_CURRENT_RESET;
			ctrl_limp_delay <= scs_pkg::CTRL_LIMP_DELAY_RESET;
			config_watchdog_retrigger <= scs_pkg::CONFIG_RESET;
		end else if (do_write) begin
			unique case (cmd_addr)
				scs_pkg::ADDR_CTRL_MUX_WATCHDOG: ctrl_mux_watchdog <= wr_data;
				scs_pkg::ADDR_CTRL_DITHER_CURRENT: ctrl_dither_current <= wr_data;
				scs_pkg::ADDR_CTRL_LIMP_DELAY: ctrl_limp_delay <= wr_data;
				scs_pkg::ADDR_CONFIG: config_watchdog_retrigger <= wr_data;
				default: ;
			endcase
		end
	end

	// Status words hold still during a frame; events meanwhile wait in pending.
	// An event arriving with a clear survives it, so no fault is lost.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_regs <= '0;
			pending <= '0;
		end else if (state == scs_pkg::ST_FRAME && !cs_sync) begin
			pending <= pending | status_events;
		end else begin
			pending <= '0;
			status_regs.detail <= (do_clear && clears(cmd_addr, scs_pkg::ADDR_STATUS_DETAIL)
				? 16'h0000 : status_regs.detail) | pending.detail | status_events.detail;
			status_regs.wd_opmode <= (do_clear && clears(cmd_addr, scs_pkg::ADDR_STATUS_WD_OPMODE)
				? 16'h0000 : status_regs.wd_opmode) | pending.wd_opmode
				| status_events.wd_opmode;
		end
	end

	// Read-and-clear hits one status word, or every one at the configuration address.
	function automatic logic clears(input logic [5:0] addr, input logic [5:0] target);
		clears = (addr == target) || (addr == scs_pkg::ADDR_CONFIG);
	endfunction

	// RAM read map; unused slots answer zero.
	function automatic logic [15:0] ram_word(input logic [5:0] addr);
		unique case (addr)
			scs_pkg::ADDR_CTRL_MUX_WATCHDOG: ram_word = ctrl_mux_watchdog;
			scs_pkg::ADDR_CTRL_DITHER_CURRENT: ram_word = ctrl_dither_current;
			scs_pkg::ADDR_CTRL_LIMP_DELAY: ram_word = ctrl_limp_delay;
			scs_pkg::ADDR_STATUS_DETAIL: ram_word = status_regs.detail;
			scs_pkg::ADDR_STATUS_WD_OPMODE: ram_word = status_regs.wd_opmode;
			scs_pkg::ADDR_TRIM_TEST_SELECT: ram_word = trim_test_select;
			scs_pkg::ADDR_CONFIG: ram_word = config_watchdog_retrigger;
			default: ram_word = 16'h0000;
		endcase
	endfunction

	// ROM read map; constants only, so nothing can alter it.
	function automatic logic [15:0] rom_word(input logic [5:0] addr);
		unique case (addr)
			scs_pkg::ROM_MAKER_HEADER: rom_word = MAKER_HEADER;
			scs_pkg::ROM_SILICON_REVISION: rom_word = SILICON_REVISION;
			scs_pkg::ROM_PART_CODE_A: rom_word = PART_CODE_A;
			scs_pkg::ROM_PART_CODE_B: rom_word = PART_CODE_B;
			scs_pkg::ROM_FRAME_FORMAT_ID: rom_word = scs_pkg::FRAME_FORMAT_WORD;
			default: rom_word = 16'h0000;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Response path.
	// ----------------------------------------------------------------
	logic [15:0] resp_data;
	logic [1:0] rx_op;
	logic [5:0] rx_addr;

	assign rx_op = rx_shift[7:6];
	assign rx_addr = rx_shift[5:0];

	// The summary is frozen at frame start; the data word is fetched once the
	// command byte is in, before any write of this frame takes place.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			summary <= '0;
			resp_data <= '0;
		end else if (frame_start) begin
			summary <= live_summary;
			resp_data <= '0;
		end else if (rx_evt && rx_cnt == scs_pkg::CNT_CMD - 5'h01) begin
			resp_data <= (rx_op == scs_pkg::OP_DEVICE_INFO) ? rom_word(rx_addr)
				: ram_word(rx_addr);
		end
	end

	// Output bit follows the falling edge count; the driver is on only while selected.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			serial_data_out <= 1'b0;
			serial_data_out_en <= 1'b0;
		end else begin
			serial_data_out_en <= !cs_sync;
			if (frame_start) begin
				serial_data_out <= live_summary[scs_pkg::GS_ANY_FAULT];
			end else if (tx_cnt < scs_pkg::CNT_CMD) begin
				serial_data_out <= summary[3'(7 - tx_cnt)];
			end else if (tx_cnt < scs_pkg::CNT_FRAME) begin
				serial_data_out <= resp_data[4'(23 - tx_cnt)];
			end else begin
				serial_data_out <= 1'b0;
			end
		end
	end

endmodule

// ==== test/scs_top_checker.sv ====
/*
 * Port assertions for the serial command and status top.
 * Assumes it is bound to scs_top and that the master keeps the serial clock low
 * while chip select moves.
 */
module scs_top_checker (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Serial link.
	input wire logic spi_clk,
	input wire logic chip_select_n,
	input wire logic serial_data_out,
	input wire logic serial_data_out_en,
	// Core side.
	input wire scs_pkg::scs_faults_s faults,
	input wire logic [15:0] ctrl_mux_watchdog,
	input wire logic [15:0] ctrl_dither_current,
	input wire logic [15:0] ctrl_limp_delay,
	input wire logic [15:0] config_watchdog_retrigger,
	input wire scs_pkg::scs_status_s status_regs
);
	// ----------------------------------------------------------------
	// Link timing and register stability.
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Chip select is sampled raw here, so four cycles cover the synchroniser delay.
	chk_hiz_idle: assert property (chip_select_n [*4] |-> !serial_data_out_en)
		else $error("output driven while deselected");
	chk_en_start: assert property ($fell(chip_select_n) |-> ##[1:4] serial_data_out_en)
		else $error("first bit not driven after select");
	chk_en_select: assert property ($rose(serial_data_out_en) |-> !chip_select_n)
		else $error("output enabled without select");
	chk_en_release: assert property ($rose(chip_select_n) |-> ##[1:4] !serial_data_out_en)
		else $error("output not released after deselect");
	chk_sdo_hold: assert property ($rose(spi_clk) && serial_data_out_en |=>
		$stable(serial_data_out) [*2])
		else $error("output moved after a rising clock");
	chk_gef_flag: assert property ($rose(serial_data_out_en) && (faults.led_overload ||
		faults.supply_undervoltage_flag || faults.light_mode_error) |-> serial_data_out)
		else $error("fault flag missing at select");
	chk_ctrl_hold: assert property ((!chip_select_n) [*4] |-> $stable(ctrl_mux_watchdog) &&
		$stable(ctrl_dither_current) && $stable(ctrl_limp_delay) &&
		$stable(config_watchdog_retrigger))
		else $error("control changed inside a frame");
	chk_status_hold: assert property ((!chip_select_n) [*4] |-> $stable(status_regs))
		else $error("status changed inside a frame");
	chk_reset_vals: assert property ($fell(sys_rst) |-> ctrl_mux_watchdog == 16'h000e &&
		ctrl_dither_current == 16'h0000 && status_regs == '0)
		else $error("wrong value after reset");

	// Main scenarios reached.
	cover property ($rose(chip_select_n));
	cover property ($changed(ctrl_limp_delay));
	cover property ($fell(status_regs.detail[0]));
endmodule

bind scs_top scs_top_checker u_checker (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.spi_clk(spi_clk),
	.chip_select_n(chip_select_n),
	.serial_data_out(serial_data_out),
	.serial_data_out_en(serial_data_out_en),
	.faults(faults),
	.ctrl_mux_watchdog(ctrl_mux_watchdog),
	.ctrl_dither_current(ctrl_dither_current),
	.ctrl_limp_delay(ctrl_limp_delay),
	.config_watchdog_retrigger(config_watchdog_retrigger),
	.status_regs(status_regs)
);

// ==== test/scs_master_model.sv ====
/*
 * Behavioural serial master for the command and status interface.
 * Assumes the bench calls frame one at a time; the link clock only runs inside frames.
 */
module scs_master_model (
	// Serial link towards the device.
	output logic spi_clk,
	output logic chip_select_n,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_out_en,
	// Captured answer.
	output logic [23:0] rx_word
);
	timeunit 1ns;
	timeprecision 100ps;
	event got;

	// Idle link: deselected, clock parked low.
	initial begin
		spi_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_data_in = 1'b0;
		rx_word = 24'h000000;
	end

	// A released output shows the inverse of the last bit, so a floating line never matches.
	// Bits are taken just before each falling edge, when the device answer has settled.
	task automatic frame(input logic [23:0] tx, input int nclk, input bit report);
		logic [23:0] rx;
		rx = 24'h000000;
		#3 chip_select_n = 1'b0;
		#64;
		for (int i = 0; i < nclk; i++) begin
			serial_data_in = tx[23 - (i % 24)];
			#32 spi_clk = 1'b1;
			#32 rx = {rx[22:0], serial_data_out_en ? serial_data_out : ~rx[0]};
			spi_clk = 1'b0;
		end
		#64 chip_select_n = 1'b1;
		rx_word = rx;
		if (report)
			-> got;
		#80;
	endtask
endmodule

// ==== test/scs_top_bench.sv ====
/*
 * Self-checking bench of the serial command and status top.
 * Assumes the master model drives the link and fault inputs stay still during frames.
 */
module scs_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] ID_HDR = 16'h2a51; // Arbitrary value.
	localparam logic [15:0] ID_REV = 16'h0007; // Arbitrary value.
	localparam logic [15:0] ID_PA = 16'h0c3d; // Arbitrary value.
	localparam logic [15:0] ID_PB = 16'h0e9f; // Arbitrary value.
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic spi_clk, chip_select_n, serial_data_in, serial_data_out, serial_data_out_en;
	logic [23:0] rx_word;
	logic [15:0] trim_test_select = 16'h0000;
	logic [15:0] ctrl_a, ctrl_b, ctrl_c, cfg;
	scs_pkg::scs_faults_s faults = '0;
	scs_pkg::scs_status_s status_events = '0;
	scs_pkg::scs_status_s status_regs;
	int failures = 0;
	int num_checks = 0;
	logic [31:0] seed = 32'h0000000d;
	logic [15:0] regs [64];
	logic [15:0] sdet = 16'h0000;
	logic [15:0] swd = 16'h0000;
	logic comm_err = 1'b0;
	logic chip_ok = 1'b0;
	logic [24:0] note;
	logic [24:0] notes [$];
	logic [5:0] ram_map [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h3e, 6'h3f, 6'h10};
	logic [5:0] rom_map [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3e, 6'h05, 6'h21};

	always #4 sys_clk = ~sys_clk;

	scs_top #(.UV_HOLD_CYCLES(20), .MAKER_HEADER(ID_HDR), .SILICON_REVISION(ID_REV),
		.PART_CODE_A(ID_PA), .PART_CODE_B(ID_PB)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
		.chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
		.faults(faults), .status_events(status_events), .trim_test_select(trim_test_select),
		.ctrl_mux_watchdog(ctrl_a), .ctrl_dither_current(ctrl_b), .ctrl_limp_delay(ctrl_c),
		.config_watchdog_retrigger(cfg), .status_regs(status_regs));

	scs_master_model mst (.spi_clk(spi_clk), .chip_select_n(chip_select_n),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_out_en(serial_data_out_en), .rx_word(rx_word));

	// ----------------------------------------------------------------
	// Reference model and helpers.
	// ----------------------------------------------------------------
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	function automatic logic [15:0] ram_exp(input logic [5:0] a);
		case (a)
			6'h01, 6'h02, 6'h03, 6'h3f: return regs[a];
			6'h04: return sdet;
			6'h05: return swd;
			6'h3e: return trim_test_select;
			default: return 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] rom_exp(input logic [5:0] a);
		case (a)
			6'h00: return ID_HDR;
			6'h01: return ID_REV;
			6'h02: return ID_PA;
			6'h03: return ID_PB;
			6'h3e: return 16'h4200;
			default: return 16'h0000;
		endcase
	endfunction

	// Top bit would mark the fault flag as not predicted; every bit is predicted here.
	function automatic logic [8:0] summ();
		logic [6:0] s;
		logic uv;
		uv = faults.regulated_micro_supply_undervoltage;
		s = {comm_err, chip_ok, faults.led_overload, faults.temp_warning,
			faults.chain_overvoltage_flag | faults.supply_overvoltage_flag,
			|faults.regulated_micro_supply_errors,
			faults.limp_data_stuck | faults.limp_watchdog_timeout | faults.limp_software |
			(uv & faults.active_mode)};
		return {1'b0, (|s) | faults.supply_undervoltage_flag | faults.light_mode_error, s};
	endfunction

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One valid frame: note the answer, run it, then follow its side effects.
	task automatic xfer(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
		logic [8:0] s;
		logic [15:0] e;
		s = summ();
		e = (op == scs_pkg::OP_DEVICE_INFO) ? rom_exp(a) : ram_exp(a);
		notes.push_back({s, e});
		mst.frame({op, a, d}, 24, 1'b1);
		if (op == scs_pkg::OP_WRITE && (a inside {6'h01, 6'h02, 6'h03, 6'h3f}))
			regs[a] = d;
		if (op == scs_pkg::OP_READ_CLEAR && (a inside {6'h04, 6'h3f}))
			sdet = 16'h0000;
		if (op == scs_pkg::OP_READ_CLEAR && (a inside {6'h05, 6'h3f}))
			swd = 16'h0000;
		comm_err = 1'b0;
		chip_ok = 1'b1;
	endtask

	task automatic bad(input int n);
		mst.frame({scs_pkg::OP_WRITE, 6'h01, 16'hffff}, n, 1'b0);
		comm_err = 1'b1;
		chip_ok = 1'b0;
	endtask

	// Status events only arrive between frames, so the sticky words are known at each start.
	task automatic pulse();
		logic [15:0] a, b;
		a = rnd();
		b = rnd();
		@(posedge sys_clk);
		status_events <= {a, b};
		@(posedge sys_clk);
		status_events <= '0;
		sdet = sdet | a;
		swd = swd | b;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic end_sim();
		$display("checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Each answer the master reports is matched against the oldest note.
	always @(mst.got) begin
		note = notes.pop_front();
		if (note[24])
			note[23] = rx_word[23];
		check("answer", {40'h0, note[23:0]}, {40'h0, rx_word});
	end

	initial begin
		#400000;
		failures++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] r;
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[1] = 16'h000e;
		repeat (2) @(posedge sys_clk);
		r = rnd();
		sys_rst <= 1'b0;
		trim_test_select <= r;
		repeat (4) @(posedge sys_clk);
		foreach (ram_map[i]) xfer(scs_pkg::OP_READ, ram_map[i], rnd());
		$display("test reset values done");
		foreach (ram_map[i]) xfer(scs_pkg::OP_WRITE, ram_map[i], rnd());
		foreach (ram_map[i]) xfer(scs_pkg::OP_READ, ram_map[i], rnd());
		check("controls", {regs[1], regs[2], regs[3], regs[63]}, {ctrl_a, ctrl_b, ctrl_c, cfg});
		$display("test writes done");
		bad(23);
		xfer(scs_pkg::OP_READ, 6'h01, 16'h0000);
		mst.frame(24'h410000, 0, 1'b0);
		xfer(scs_pkg::OP_READ, 6'h02, 16'h0000);
		bad(25);
		xfer(scs_pkg::OP_READ, 6'h01, 16'h0000);
		$display("test clock counts done");
		pulse();
		xfer(scs_pkg::OP_READ, 6'h04, 16'h0000);
		xfer(scs_pkg::OP_READ_CLEAR, 6'h04, 16'hffff);
		xfer(scs_pkg::OP_READ, 6'h04, 16'h0000);
		xfer(scs_pkg::OP_READ_CLEAR, 6'h05, rnd());
		pulse();
		xfer(scs_pkg::OP_READ_CLEAR, 6'h3f, rnd());
		check("status", 64'h0, {32'h0, status_regs});
		$display("test status done");
		foreach (rom_map[i]) xfer(scs_pkg::OP_DEVICE_INFO, rom_map[i], rnd());
		check("controls", {regs[1], regs[2], regs[3], regs[63]}, {ctrl_a, ctrl_b, ctrl_c, cfg});
		$display("test device info done");
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			faults <= scs_pkg::scs_faults_s'(r[14:0]);
			repeat (30) @(posedge sys_clk);
			xfer(scs_pkg::OP_READ, 6'h03, 16'h0000);
		end
		$display("test fault summary done");
		end_sim();
	end
endmodule
